// File: tmr_pkg.sv
// Purpose: constants for the capture/compare time base timer
// Assumes: plain register port, 8-bit data, byte-wide registers
// Notes: offsets are local register indices
package tmr_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_COUNT_LOW = 3'h1;
  localparam logic [2:0] OFS_COUNT_HIGH = 3'h2;
  localparam logic [2:0] OFS_CAPCMP_LOW = 3'h3;
  localparam logic [2:0] OFS_CAPCMP_HIGH = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;
  localparam logic [2:0] OFS_CCP_MODE = 3'h6;
  localparam int BIT_CS_HI = 7;
  localparam int BIT_CS_LO = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_SYNC_DIS = 2;
  localparam int BIT_RUN = 0;
  localparam logic [7:0] CONTROL_WMASK = 8'hfd;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS = 2'h1;
  localparam logic [1:0] CS_EXT = 2'h2;
  localparam logic [1:0] CS_CAP_SENSE_OSCILLATOR = 2'h3;
  // status bits: 0 overflow flag, 1 capcmp flag
  localparam int BIT_OVF = 0;
  localparam int BIT_CCF = 1;
  // ccp mode: 0 off, 1 capture, 2 compare, 3 compare + special trigger
  localparam logic [1:0] CCP_OFF = 2'h0;
  localparam logic [1:0] CCP_CAPTURE = 2'h1;
  localparam logic [1:0] CCP_COMPARE = 2'h2;
  localparam logic [1:0] CCP_SPECIAL = 2'h3;
  localparam int INSTR_DIV = 4;
endpackage : tmr_pkg

// File: timebase_timer.sv
// Purpose: 16-bit timer acting as the time base of a capture/compare unit
// Assumes: all inputs synchronous to clock_i; external sources sampled by edge
// Notes: ccp_mode register bits 1:0 steer capture/compare; capture event is an input
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timebase_timer
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // clock sources and capture event
  input wire logic ext_count_input_i,
  input wire logic crystal_in_pin_i,
  input wire logic cap_sense_oscillator_i,
  input wire logic capture_event_i,
  // outputs
  output logic crystal_osc_enable_o,
  output logic compare_event_o,
  output logic special_trigger_o,
  output logic timer_overflow_flag_o
);
  logic [7:0] control_ff;
  logic [15:0] count_ff;
  logic [15:0] capcmp_ff;
  logic [1:0] ccp_mode_ff;
  logic ovf_ff;
  logic ccf_ff;
  logic [1:0] instr_div_ff;
  logic [2:0] sync_ff;
  logic raw_prev_ff;
  logic [2:0] pre_ff;
  logic [7:0] rdata_ff;
  logic cmp_ff;
  logic sev_ff;

  logic [1:0] cs;
  logic [1:0] ps;
  logic src_lvl;
  logic ext_sel;
  logic src_edge;
  logic tick;
  logic match;
  logic special;
  logic wr_low;
  logic wr_high;

  assign cs = control_ff[BIT_CS_HI:BIT_CS_LO];
  assign ps = control_ff[BIT_PS_HI:BIT_PS_LO];
  assign ext_sel = cs[1];
  assign wr_low = wr_i && (addr_i == OFS_COUNT_LOW);
  assign wr_high = wr_i && (addr_i == OFS_COUNT_HIGH);

  // source mux: crystal replaces the pin when the oscillator runs
  always_comb begin
    case (cs)
      CS_CAP_SENSE_OSCILLATOR: src_lvl = cap_sense_oscillator_i;
      CS_EXT: src_lvl = control_ff[BIT_OSC_EN] ? crystal_in_pin_i : ext_count_input_i;
      default: src_lvl = 1'b0;
    endcase
  end

  // two-stage synchroniser; the third stage is only the edge reference of the synced path
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sync_ff <= 3'h0;
      raw_prev_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], src_lvl};
      raw_prev_ff <= src_lvl;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      instr_div_ff <= 2'h0;
    end else begin
      instr_div_ff <= instr_div_ff + 2'h1;
    end
  end

  // rising edges only; unsynchronised path gives two cycles less latency
  always_comb begin
    case (cs)
      CS_INSTR: src_edge = (instr_div_ff == 2'(INSTR_DIV - 1));
      CS_SYS: src_edge = 1'b1;
      default: begin
        if (control_ff[BIT_SYNC_DIS]) begin
          src_edge = src_lvl && !raw_prev_ff;
        end else begin
          src_edge = sync_ff[1] && !sync_ff[2];
        end
      end
    endcase
  end

  // prescaler: tick on every 1, 2, 4 or 8 source edges
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pre_ff <= 3'h0;
    end else if (!control_ff[BIT_RUN]) begin
      pre_ff <= 3'h0;
    end else if (src_edge) begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  always_comb begin
    case (ps)
      2'h0: tick = src_edge;
      2'h1: tick = src_edge && pre_ff[0];
      2'h2: tick = src_edge && (pre_ff[1:0] == 2'h3);
      default: tick = src_edge && (pre_ff == 3'h7);
    endcase
    tick = tick && control_ff[BIT_RUN];
  end

  assign match = ccp_mode_ff[1] && (count_ff == capcmp_ff);
  assign special = match && (ccp_mode_ff == CCP_SPECIAL);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count_ff <= 16'h0000;
    end else if (wr_low || wr_high) begin
      if (wr_low) count_ff[7:0] <= wdata_i;
      if (wr_high) count_ff[15:8] <= wdata_i;
    end else if (special) begin
      count_ff <= 16'h0000;
    end else if (tick) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      control_ff <= CONTROL_RESET;
      ccp_mode_ff <= CCP_OFF;
    end else if (wr_i) begin
      if (addr_i == OFS_CONTROL) control_ff <= wdata_i & CONTROL_WMASK;
      if (addr_i == OFS_CCP_MODE) ccp_mode_ff <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      capcmp_ff <= 16'h0000;
    end else if (capture_event_i && (ccp_mode_ff == CCP_CAPTURE)) begin
      capcmp_ff <= count_ff;
    end else if (wr_i && addr_i == OFS_CAPCMP_LOW) begin
      capcmp_ff[7:0] <= wdata_i;
    end else if (wr_i && addr_i == OFS_CAPCMP_HIGH) begin
      capcmp_ff[15:8] <= wdata_i;
    end
  end

  // flags: hardware set wins over a software write of zero
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ovf_ff <= 1'b0;
      ccf_ff <= 1'b0;
    end else begin
      if (tick && !special && !wr_low && !wr_high && count_ff == 16'hffff) begin
        ovf_ff <= 1'b1;
      end else if (wr_i && addr_i == OFS_STATUS) begin
        ovf_ff <= wdata_i[BIT_OVF];
      end
      if (match || (capture_event_i && ccp_mode_ff == CCP_CAPTURE)) begin
        ccf_ff <= 1'b1;
      end else if (wr_i && addr_i == OFS_STATUS) begin
        ccf_ff <= wdata_i[BIT_CCF];
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cmp_ff <= 1'b0;
      sev_ff <= 1'b0;
    end else begin
      cmp_ff <= match;
      sev_ff <= special;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        OFS_CONTROL: rdata_ff <= control_ff;
        OFS_COUNT_LOW: rdata_ff <= count_ff[7:0];
        OFS_COUNT_HIGH: rdata_ff <= count_ff[15:8];
        OFS_CAPCMP_LOW: rdata_ff <= capcmp_ff[7:0];
        OFS_CAPCMP_HIGH: rdata_ff <= capcmp_ff[15:8];
        OFS_STATUS: rdata_ff <= {6'h00, ccf_ff, ovf_ff};
        OFS_CCP_MODE: rdata_ff <= {6'h00, ccp_mode_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_o = rdata_ff;
  assign crystal_osc_enable_o = control_ff[BIT_OSC_EN];
  assign compare_event_o = cmp_ff;
  assign special_trigger_o = sev_ff;
  assign timer_overflow_flag_o = ovf_ff;

  clear_no_ovf_a: assert property (@(posedge clock_i) disable iff (reset_i)
    special && !tick |=> $stable(ovf_ff) || $past(wr_i)) else $error("trigger set overflow");
  trig_clears_a: assert property (@(posedge clock_i) disable iff (reset_i)
    special && !wr_low && !wr_high |=> count_ff == 16'h0000) else $error("trigger no clear");
  write_wins_a: assert property (@(posedge clock_i) disable iff (reset_i)
    special && wr_low |=> count_ff[7:0] == $past(wdata_i)) else $error("write lost");
  capture_copy_a: assert property (@(posedge clock_i) disable iff (reset_i)
    capture_event_i && ccp_mode_ff == CCP_CAPTURE |=> capcmp_ff == $past(count_ff))
    else $error("capture wrong");
  compare_evt_a: assert property (@(posedge clock_i) disable iff (reset_i)
    match |=> compare_event_o) else $error("compare missed");
  ccp_flag_a: assert property (@(posedge clock_i) disable iff (reset_i)
    special |=> ccf_ff) else $error("ccp flag not set");
  wrap_flag_a: assert property (@(posedge clock_i) disable iff (reset_i)
    tick && !special && !wr_i && count_ff == 16'hffff |=> ovf_ff && count_ff == 16'h0000)
    else $error("wrap wrong");
  stop_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    !control_ff[BIT_RUN] && !wr_i && !special |=> $stable(count_ff)) else $error("count moved");
  osc_en_a: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == OFS_CONTROL |=> crystal_osc_enable_o == $past(wdata_i[BIT_OSC_EN]))
    else $error("osc enable");
  period_a: assert property (@(posedge clock_i) disable iff (reset_i)
    ccp_mode_ff == CCP_SPECIAL && !wr_i && count_ff == capcmp_ff |=> count_ff == 16'h0000)
    else $error("period wrong");
  cov_wrap_c: cover property (@(posedge clock_i) tick && count_ff == 16'hffff);
  cov_special_c: cover property (@(posedge clock_i) special);
  cov_capture_c: cover property (@(posedge clock_i) capture_event_i && ccp_mode_ff == CCP_CAPTURE);
endmodule : timebase_timer
`default_nettype wire

// File: capcmp_partner.sv
// Purpose: far-side source model, five rising edges on one chosen clock source line
// Assumes: go_i is a one-cycle pulse; sel_i 0 pin, 1 crystal, 2 cap osc
// Notes: unselected lines stay low, as an idle source would
`timescale 1ns/1ps
`default_nettype none
module capcmp_partner (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // control
  input wire logic go_i,
  input wire logic [1:0] sel_i,
  // source lines
  output logic ext_count_input_o,
  output logic crystal_in_pin_o,
  output logic cap_sense_oscillator_o
);
  logic [5:0] phase_ff;
  logic level;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) phase_ff <= 6'h00;
    else if (go_i) phase_ff <= 6'h28;
    else if (phase_ff != 6'h00) phase_ff <= phase_ff - 6'h01;
  end
  // bit 2 of a 40..1 countdown gives five high phases of four cycles
  assign level = phase_ff[2];
  assign ext_count_input_o = level & (sel_i == 2'h0);
  assign crystal_in_pin_o = level & (sel_i == 2'h1);
  assign cap_sense_oscillator_o = level & (sel_i == 2'h2);
endmodule : capcmp_partner
`default_nettype wire

// File: timebase_timer_test.sv
// Purpose: self-checking bench for the capture/compare time base timer
// Assumes: tasks are entered just after a rising edge
// Notes: counts read after stopping the timer, so small windows allow for stop latency
`timescale 1ns/1ps
`default_nettype none
module timebase_timer_test;
  import tmr_pkg::*;
  logic clock_i, reset_i, wr_i, rd_i, cap_i, go, ext, xtal, caps, osc_o, cmp_o, trg_o, ovf_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic [1:0] sel;
  int mismatches, samples_checked, cyc, n;
  logic [7:0] ctl_tab [4] = '{8'h85, 8'h81, 8'h89, 8'hc1};
  logic [1:0] sel_tab [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  timebase_timer dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_count_input_i(ext),
    .crystal_in_pin_i(xtal), .cap_sense_oscillator_i(caps), .capture_event_i(cap_i),
    .crystal_osc_enable_o(osc_o), .compare_event_o(cmp_o), .special_trigger_o(trg_o),
    .timer_overflow_flag_o(ovf_o));
  capcmp_partner far (.clock_i(clock_i), .reset_i(reset_i), .go_i(go), .sel_i(sel),
    .ext_count_input_o(ext), .crystal_in_pin_o(xtal), .cap_sense_oscillator_o(caps));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    samples_checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      mismatches++;
      $display("FAIL %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
    @(posedge clock_i);
  endtask : rd
  task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
    wr(OFS_COUNT_HIGH, hi);
    wr(OFS_COUNT_LOW, lo);
  endtask : set_count
  task automatic wait_on(input int which);
    n = 0;
    @(negedge clock_i);
    while (((which == 0) ? cmp_o : trg_o) !== 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    d = {7'h00, (which == 0) ? cmp_o : trg_o};
    @(posedge clock_i);
  endtask : wait_on
  initial begin
    mismatches = 0; samples_checked = 0; reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0;
    addr_i = 3'h0; wdata_i = 8'h00; cap_i = 1'b0; go = 1'b0; sel = 2'h0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(OFS_CONTROL); chk(d, CONTROL_RESET);
    wr(OFS_CONTROL, 8'hff); rd(OFS_CONTROL); chk(d, 8'hfd);
    chk({7'h00, osc_o}, 8'h01);
    wr(OFS_CONTROL, 8'h00); rd(OFS_CONTROL); chk({7'h00, osc_o}, 8'h00);
    wr(3'h7, 8'h5a); rd(3'h7); chk(d, 8'h00);
    // four system clock prescales, then the instruction clock
    for (int i = 0; i < 5; i++) begin
      set_count(8'h00, 8'h00);
      wr(OFS_CONTROL, (i < 4) ? (8'h41 | 8'(i << 4)) : 8'h01);
      repeat (63) @(posedge clock_i);
      wr(OFS_CONTROL, 8'h00);
      rd(OFS_COUNT_LOW);
      chk_rng(d, (i < 4) ? 8'(64 >> i) - 8'h01 : 8'h0f, (i < 4) ? 8'(64 >> i) + 8'h02 : 8'h12);
    end
    set_count(8'hff, 8'hf0); wr(OFS_CONTROL, 8'h41); repeat (20) @(posedge clock_i);
    wr(OFS_CONTROL, 8'h00); chk({7'h00, ovf_o}, 8'h01);
    rd(OFS_COUNT_HIGH); chk(d, 8'h00);
    wr(OFS_STATUS, 8'h00); rd(OFS_STATUS); chk(d, 8'h00);
    // external sources: pin raw, pin synchronised, crystal, cap osc
    for (int i = 0; i < 4; i++) begin
      set_count(8'h00, 8'h00); wr(OFS_CONTROL, ctl_tab[i]); sel <= sel_tab[i];
      go <= 1'b1; @(posedge clock_i); go <= 1'b0;
      repeat (50) @(posedge clock_i);
      chk({7'h00, osc_o}, {7'h00, ctl_tab[i][3]});
      wr(OFS_CONTROL, 8'h00); rd(OFS_COUNT_LOW); chk(d, 8'h05);
    end
    set_count(8'h12, 8'h34); wr(OFS_CCP_MODE, {6'h00, CCP_CAPTURE});
    cap_i <= 1'b1; @(posedge clock_i); cap_i <= 1'b0; @(posedge clock_i);
    rd(OFS_CAPCMP_LOW); chk(d, 8'h34);
    rd(OFS_CAPCMP_HIGH); chk(d, 8'h12);
    wr(OFS_CAPCMP_LOW, 8'h05); wr(OFS_CAPCMP_HIGH, 8'h00); wr(OFS_CCP_MODE, {6'h00, CCP_COMPARE});
    set_count(8'h00, 8'h00); wr(OFS_CONTROL, 8'h41);
    wait_on(0); chk(d, 8'h01);
    repeat (4) @(posedge clock_i);
    wr(OFS_CONTROL, 8'h00); rd(OFS_COUNT_LOW); chk_rng(d, 8'h07, 8'h0c);
    wr(OFS_CCP_MODE, {6'h00, CCP_SPECIAL}); set_count(8'h00, 8'h00);
    wr(OFS_CONTROL, 8'h01);
    // clear lands one clock after the match, so the period is capcmp instruction ticks
    wait_on(1); wait_on(1); chk(d, 8'h01);
    chk(8'(n + 1), 8'(5 * INSTR_DIV));
    chk({7'h00, ovf_o}, 8'h00);
    wr(OFS_CONTROL, 8'h00); rd(OFS_STATUS); chk(d, 8'h02);
    wr(OFS_CAPCMP_LOW, 8'h00); set_count(8'h00, 8'h00);
    wr(OFS_COUNT_LOW, 8'h07); rd(OFS_COUNT_LOW); chk(d, 8'h07);
    give_verdict();
  end
endmodule : timebase_timer_test
`default_nettype wire
